// ===== logic/adc_ctrl_pkg.sv
// Package: register map, field layout, reset values and timing for the
// converter result and clock control block.
// Assumes a 32-bit AXI4-Lite register bus and a 20 MHz bus clock.
package adc_ctrl_pkg;

  localparam int unsigned ADDR_W = 4;
  localparam logic [ADDR_W-1:0] OFS_STATUS_CONTROL = 4'h0;
  localparam logic [ADDR_W-1:0] OFS_RESULT_HIGH = 4'h4;
  localparam logic [ADDR_W-1:0] OFS_RESULT_LOW = 4'h8;
  localparam logic [ADDR_W-1:0] OFS_CLOCK_MODE = 4'hc;

  // Status/control layout.
  localparam int unsigned SC_CHAN_LSB = 0;
  localparam int unsigned SC_CONT_BIT = 5;
  localparam int unsigned SC_FLAG_BIT = 7;
  localparam logic [4:0] CHAN_OFF = 5'h1f;
  localparam logic [4:0] SC_CHAN_RESET = 5'h1f;

  // Clock/mode layout.
  localparam int unsigned CK_ICLK_BIT = 0;
  localparam int unsigned CK_MODE_LSB = 1;
  localparam int unsigned CK_LSMP_BIT = 3;
  localparam int unsigned CK_DIV_LSB = 4;
  localparam int unsigned CK_LPC_BIT = 6;
  localparam int unsigned CK_ACLK_BIT = 7;
  localparam logic [7:0] CLOCK_MODE_RESET = 8'h00;

  typedef enum logic [1:0] {
    MODE_8_SW = 2'b00,
    MODE_10_SW = 2'b01,
    MODE_RSVD = 2'b10,
    MODE_10_HW = 2'b11
  } result_mode_t;

  // Sample phase in half converter cycles, as printed: 3.5 and 23.5.
  localparam int unsigned SHORT_SAMPLE_HALF = 7;
  localparam int unsigned LONG_SAMPLE_HALF = 47;
  // Whole converter-clock ticks, rounded up from the half-cycle figure.
  localparam logic [4:0] SHORT_SAMPLE_TICKS = 5'((SHORT_SAMPLE_HALF + 1) / 2);
  localparam logic [4:0] LONG_SAMPLE_TICKS = 5'((LONG_SAMPLE_HALF + 1) / 2);

  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

endpackage

// ===== logic/result_if.sv
// Interface: carries conversion results and read strobes between the
// control top and the result register pair.
// Assumes all signals are on the one bus clock.
`timescale 1ns/1ps
`default_nettype none
interface result_if;
  logic load;
  logic [9:0] value;
  logic mode8;
  logic read_high;
  logic read_low;
  logic [7:0] high_byte;
  logic [7:0] low_byte;
  logic locked;

  modport ctrl (output load, output value, output mode8, output read_high,
                output read_low, input high_byte, input low_byte,
                input locked);
  modport regs (input load, input value, input mode8, input read_high,
                input read_low, output high_byte, output low_byte,
                output locked);
endinterface
`default_nettype wire

// ===== logic/result_regs.sv
// Result register pair with the high-then-low read interlock.
// Assumes value is already rounded to the selected width.
`timescale 1ns/1ps
`default_nettype none
module result_regs (
  input wire logic aclk,
  input wire logic aresetn,
  result_if.regs rif
);
  logic locked_reg;
  logic take;

  // A high read in a 10-bit mode freezes both bytes until the low read.
  assign take = rif.load && (!locked_reg || rif.mode8);
  assign rif.locked = locked_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      locked_reg <= 1'b0;
    end else if (rif.read_low || rif.mode8) begin
      locked_reg <= 1'b0;
    end else if (rif.read_high) begin
      locked_reg <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rif.high_byte <= 8'h00;
      rif.low_byte <= 8'h00;
    end else if (take) begin
      // Only bits 9:8 reach the high byte; the rest read zero.
      rif.high_byte <= {6'h00, rif.mode8 ? 2'b00 : rif.value[9:8]};
      rif.low_byte <= rif.value[7:0];
    end
  end
endmodule // result_regs
`default_nettype wire

// ===== logic/clock_divider.sv
// Divides the selected input-clock tick stream by 1, 2, 4 or 8.
// Assumes src_tick is a one-cycle pulse on the bus clock.
`timescale 1ns/1ps
`default_nettype none
module clock_divider #(
  parameter int unsigned CNT_W = 3
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic clear,
  input wire logic src_tick,
  input wire logic [1:0] ratio_code,
  output logic conv_tick
);
  logic [CNT_W-1:0] count_reg;
  logic [CNT_W-1:0] limit;

  // Code n divides by two to the n.
  assign limit = CNT_W'((1 << ratio_code) - 1);
  assign conv_tick = src_tick && (count_reg >= limit);

  always_ff @(posedge aclk) begin
    if (!aresetn || clear) begin
      count_reg <= '0;
    end else if (conv_tick) begin
      count_reg <= '0;
    end else if (src_tick) begin
      count_reg <= count_reg + 1'b1;
    end
  end
endmodule // clock_divider
`default_nettype wire

// ===== logic/adc_ctrl.sv
// Converter result and clock control: AXI4-Lite registers, clock source
// selection, divider, sample sequencing and result transfer.
// Assumes the analog core runs on aclk enables and that the alternate and
// asynchronous clock sources arrive as slow level pins.
//
// What this block does
// - High result byte loads its top bits each completion; unused bits zero.
// - Reading the high byte freezes both result bytes until low byte read.
// - Results finishing while frozen are thrown away.
// - Eight-bit mode has no high/low read interlock.
// - Low result byte loads its low bits each completion, under interlock.
// - Low-power bit selects reduced-power, slower converter configuration.
// - Divider codes 00..11 divide the input clock by 1, 2, 4, 8.
// - Without async clock, select bit picks bus clock (1) or alternate (0).
// - Converter clock is the selected input clock over the divide ratio.
// - Mode 00 8-bit software, 01 10-bit software, 11 10-bit hardware.
// - Reset sets eight-bit software-triggered mode.
// - Results round to the selected width of 8 or 10 bits.
// - Long-sample bit gives 23.5 cycles sampling, else 3.5 cycles; the block counts 24 and 4 converter ticks.
// - Async enable uses async source, runs in stop, generator only converting.
// - Without async enable, conversions do not continue in stop mode.
// - Complete flag sets per conversion; cleared by control write or low read.
// - Control write aborts and restarts conversion unless channel is all ones.
// - Continuous mode ends on reset, stop without async enable, clock-register write, control write.
`timescale 1ns/1ps
`default_nettype none
module adc_ctrl (
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite slave.
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // System side.
  input wire logic stop_mode,
  input wire logic hw_trigger,
  input wire logic alt_clk_pin,
  input wire logic async_clk_pin,
  // Analog core side.
  input wire logic [9:0] core_result,
  input wire logic core_done,
  output logic [4:0] core_channel,
  output logic core_sample,
  output logic core_convert,
  output logic converter_clock,
  output logic low_power_config,
  output logic async_clock_run
);

  ////////////////////////////////////////////////////////////////////////////
  // Registers and bus handshake.

  typedef enum logic [1:0] {
    SEQ_IDLE,
    SEQ_ARMED,
    SEQ_SAMPLE,
    SEQ_CONVERT
  } seq_state_t;

  logic [4:0] channel_select_reg;
  logic continuous_convert_reg;
  logic conversion_complete_flag_reg;
  logic [7:0] clock_mode_reg;
  seq_state_t seq_reg;
  logic [4:0] sample_cnt_reg;

  logic wr_fire;
  logic rd_fire;
  logic sc_write;
  logic ck_write;
  logic done_evt;
  logic [31:0] rd_value;
  logic rd_ok;

  result_if rif ();

  function automatic logic is_mapped(input logic [3:0] addr);
    is_mapped = (addr == adc_ctrl_pkg::OFS_STATUS_CONTROL) ||
                (addr == adc_ctrl_pkg::OFS_RESULT_HIGH) ||
                (addr == adc_ctrl_pkg::OFS_RESULT_LOW) ||
                (addr == adc_ctrl_pkg::OFS_CLOCK_MODE);
  endfunction

  // Address and data are taken together, so there is no half-write state.
  assign wr_fire = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
  assign s_axi_awready = wr_fire;
  assign s_axi_wready = wr_fire;
  assign s_axi_arready = !s_axi_rvalid;
  assign rd_fire = s_axi_arvalid && !s_axi_rvalid;

  // Registers are one byte wide; only lane 0 writes them.
  assign sc_write = wr_fire && s_axi_wstrb[0] &&
                    (s_axi_awaddr == adc_ctrl_pkg::OFS_STATUS_CONTROL);
  assign ck_write = wr_fire && s_axi_wstrb[0] &&
                    (s_axi_awaddr == adc_ctrl_pkg::OFS_CLOCK_MODE);

  assign rif.read_high = rd_fire &&
                         (s_axi_araddr == adc_ctrl_pkg::OFS_RESULT_HIGH);
  assign rif.read_low = rd_fire &&
                        (s_axi_araddr == adc_ctrl_pkg::OFS_RESULT_LOW);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= adc_ctrl_pkg::RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= is_mapped(s_axi_awaddr) ? adc_ctrl_pkg::RESP_OKAY
                                             : adc_ctrl_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  always_comb begin
    rd_value = 32'h0000_0000;
    rd_ok = 1'b1;
    case (s_axi_araddr)
      adc_ctrl_pkg::OFS_STATUS_CONTROL: begin
        rd_value[adc_ctrl_pkg::SC_FLAG_BIT] = conversion_complete_flag_reg;
        rd_value[adc_ctrl_pkg::SC_CONT_BIT] = continuous_convert_reg;
        rd_value[adc_ctrl_pkg::SC_CHAN_LSB +: 5] = channel_select_reg;
      end
      adc_ctrl_pkg::OFS_RESULT_HIGH: rd_value[7:0] = rif.high_byte;
      adc_ctrl_pkg::OFS_RESULT_LOW: rd_value[7:0] = rif.low_byte;
      adc_ctrl_pkg::OFS_CLOCK_MODE: rd_value[7:0] = clock_mode_reg;
      default: rd_ok = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= adc_ctrl_pkg::RESP_OKAY;
    end else if (rd_fire) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_value;
      s_axi_rresp <= rd_ok ? adc_ctrl_pkg::RESP_OKAY
                           : adc_ctrl_pkg::RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      clock_mode_reg <= adc_ctrl_pkg::CLOCK_MODE_RESET;
    end else if (ck_write) begin
      clock_mode_reg <= s_axi_wdata[7:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      channel_select_reg <= adc_ctrl_pkg::SC_CHAN_RESET;
    end else if (sc_write) begin
      channel_select_reg <= s_axi_wdata[adc_ctrl_pkg::SC_CHAN_LSB +: 5];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Clock/mode fields.

  logic async_clock_enable;
  logic iclk_bus;
  logic long_sample_select;
  logic [1:0] clock_divide_ratio;
  adc_ctrl_pkg::result_mode_t mode;
  logic stop_halt;

  assign async_clock_enable = clock_mode_reg[adc_ctrl_pkg::CK_ACLK_BIT];
  assign iclk_bus = clock_mode_reg[adc_ctrl_pkg::CK_ICLK_BIT];
  assign long_sample_select = clock_mode_reg[adc_ctrl_pkg::CK_LSMP_BIT];
  assign clock_divide_ratio = clock_mode_reg[adc_ctrl_pkg::CK_DIV_LSB +: 2];
  assign mode = adc_ctrl_pkg::result_mode_t'(
                  clock_mode_reg[adc_ctrl_pkg::CK_MODE_LSB +: 2]);
  assign low_power_config = clock_mode_reg[adc_ctrl_pkg::CK_LPC_BIT];
  // Stop only halts work when the bus-derived clocks would vanish.
  assign stop_halt = stop_mode && !async_clock_enable;

  ////////////////////////////////////////////////////////////////////////////
  // Clock source selection.

  logic alt_meta_reg;
  logic alt_sync_reg;
  logic alt_prev_reg;
  logic async_meta_reg;
  logic async_sync_reg;
  logic async_prev_reg;
  logic alt_tick;
  logic async_tick;
  logic src_tick;
  logic conv_tick;
  logic converting;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      alt_meta_reg <= 1'b0;
      alt_sync_reg <= 1'b0;
      alt_prev_reg <= 1'b0;
      async_meta_reg <= 1'b0;
      async_sync_reg <= 1'b0;
      async_prev_reg <= 1'b0;
    end else begin
      alt_meta_reg <= alt_clk_pin;
      alt_sync_reg <= alt_meta_reg;
      alt_prev_reg <= alt_sync_reg;
      async_meta_reg <= async_clk_pin;
      async_sync_reg <= async_meta_reg;
      async_prev_reg <= async_sync_reg;
    end
  end

  assign alt_tick = alt_sync_reg && !alt_prev_reg;
  assign async_tick = async_sync_reg && !async_prev_reg;

  always_comb begin
    if (async_clock_enable) begin
      src_tick = async_tick;
    end else if (iclk_bus) begin
      src_tick = !stop_mode;
    end else begin
      src_tick = alt_tick && !stop_mode;
    end
  end

  assign converting = (seq_reg == SEQ_SAMPLE) || (seq_reg == SEQ_CONVERT);
  // The asynchronous generator is kept off between conversions to save power.
  assign async_clock_run = async_clock_enable && converting;

  clock_divider #(
    .CNT_W(3)
  ) u_div (
    .aclk(aclk),
    .aresetn(aresetn),
    .clear(ck_write),
    .src_tick(src_tick),
    .ratio_code(clock_divide_ratio),
    .conv_tick(conv_tick)
  );

  assign converter_clock = conv_tick;

  ////////////////////////////////////////////////////////////////////////////
  // Conversion sequencer.

  logic start_req;
  logic trig_ok;
  logic [4:0] sample_len;

  // A channel of all ones turns the converter off instead of starting it.
  assign start_req = sc_write &&
      (s_axi_wdata[adc_ctrl_pkg::SC_CHAN_LSB +: 5] != adc_ctrl_pkg::CHAN_OFF);
  assign trig_ok = (mode != adc_ctrl_pkg::MODE_10_HW) || hw_trigger;
  assign sample_len = long_sample_select ? adc_ctrl_pkg::LONG_SAMPLE_TICKS
                                         : adc_ctrl_pkg::SHORT_SAMPLE_TICKS;
  assign done_evt = (seq_reg == SEQ_CONVERT) && core_done;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      continuous_convert_reg <= 1'b0;
    end else if (sc_write) begin
      continuous_convert_reg <= s_axi_wdata[adc_ctrl_pkg::SC_CONT_BIT];
    end else if (ck_write || stop_halt) begin
      continuous_convert_reg <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      seq_reg <= SEQ_IDLE;
      sample_cnt_reg <= 5'h00;
    end else if (sc_write) begin
      // A new control write aborts whatever was running.
      seq_reg <= start_req ? SEQ_ARMED : SEQ_IDLE;
      sample_cnt_reg <= 5'h00;
    end else if (ck_write || stop_halt) begin
      seq_reg <= SEQ_IDLE;
      sample_cnt_reg <= 5'h00;
    end else begin
      case (seq_reg)
        SEQ_IDLE: sample_cnt_reg <= 5'h00;
        SEQ_ARMED: begin
          if (trig_ok) begin
            seq_reg <= SEQ_SAMPLE;
            sample_cnt_reg <= 5'h00;
          end
        end
        SEQ_SAMPLE: begin
          if (conv_tick) begin
            if (sample_cnt_reg == sample_len - 5'h01) begin
              seq_reg <= SEQ_CONVERT;
            end
            sample_cnt_reg <= sample_cnt_reg + 5'h01;
          end
        end
        SEQ_CONVERT: begin
          if (core_done) begin
            seq_reg <= continuous_convert_reg ? SEQ_ARMED : SEQ_IDLE;
          end
        end
        default: seq_reg <= SEQ_IDLE;
      endcase
    end
  end

  assign core_channel = channel_select_reg;
  assign core_sample = (seq_reg == SEQ_SAMPLE);
  assign core_convert = (seq_reg == SEQ_CONVERT);

  ////////////////////////////////////////////////////////////////////////////
  // Completion flag and result transfer.

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      conversion_complete_flag_reg <= 1'b0;
    end else if (done_evt) begin
      // The set wins when a completion meets a clearing access.
      conversion_complete_flag_reg <= 1'b1;
    end else if (sc_write || rif.read_low) begin
      conversion_complete_flag_reg <= 1'b0;
    end
  end

  function automatic logic [9:0] round_result(input logic [9:0] raw,
                                              input logic to8);
    logic [8:0] sum;
    sum = {1'b0, raw[9:2]} + {8'h00, raw[1]};
    if (!to8) begin
      round_result = raw;
    end else if (sum[8]) begin
      round_result = 10'h0ff;
    end else begin
      round_result = {2'b00, sum[7:0]};
    end
  endfunction

  assign rif.mode8 = (mode == adc_ctrl_pkg::MODE_8_SW);
  assign rif.load = done_evt;
  assign rif.value = round_result(core_result, rif.mode8);

  result_regs u_res (
    .aclk(aclk),
    .aresetn(aresetn),
    .rif(rif)
  );

endmodule // adc_ctrl
`default_nettype wire

// ===== test/adc_ctrl_props.sv
// Checker for the converter control top: tick spacing, sample length,
// register mirrors and the order of the converter link.
// Assumes it is bound to adc_ctrl and sees only that module's ports.
`timescale 1ns/1ps
`default_nettype none
module adc_ctrl_props (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_bvalid,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic stop_mode,
  input wire logic core_done,
  input wire logic [4:0] core_channel,
  input wire logic core_sample,
  input wire logic core_convert,
  input wire logic converter_clock,
  input wire logic low_power_config,
  input wire logic async_clock_run
);
  logic wr_ck;
  logic [7:0] ck_reg;
  logic [3:0] gap;
  logic armed;
  logic [4:0] samp;
  assign wr_ck = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid &&
    s_axi_wstrb[0] && s_axi_awaddr == adc_ctrl_pkg::OFS_CLOCK_MODE;
  ////////////////////////////////////////////////////////////////////////////
  // The divider restarts on a clock write, so spacing is judged only between
  // two ticks with no clock write or stop in between.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ck_reg <= adc_ctrl_pkg::CLOCK_MODE_RESET;
    end else if (wr_ck) begin
      ck_reg <= s_axi_wdata[7:0];
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn || wr_ck || stop_mode) begin
      armed <= 1'b0;
    end else if (converter_clock) begin
      armed <= 1'b1;
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn || converter_clock) begin
      gap <= 4'h0;
    end else begin
      gap <= gap + 4'h1;
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn || !core_sample) begin
      samp <= 5'h00;
    end else if (converter_clock) begin
      samp <= samp + 5'h01;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_low_power_bit: assert property (
    low_power_config == ck_reg[6]) else $error("low power bit wrong");
  a_divide_by_eight: assert property (
    converter_clock && armed && ck_reg[5:4] == 2'b11 && ck_reg[0] &&
    !ck_reg[7] |-> gap == 4'h7) else $error("divide by eight spacing");
  a_bus_clock_tick: assert property (
    armed && ck_reg[0] && !ck_reg[7] && ck_reg[5:4] == 2'b00 && !stop_mode
    |-> converter_clock) else $error("bus clock tick missing");
  a_sample_length: assert property (
    $rose(core_convert) |-> samp == (ck_reg[3] ?
    adc_ctrl_pkg::LONG_SAMPLE_TICKS : adc_ctrl_pkg::SHORT_SAMPLE_TICKS))
    else $error("sample length wrong");
  a_channel_off: assert property (
    core_sample |-> core_channel != adc_ctrl_pkg::CHAN_OFF)
    else $error("sampling with channel off");
  a_done_ends_convert: assert property (
    core_convert && core_done |=> !core_convert)
    else $error("convert held after done");
  a_stop_halts: assert property (
    (stop_mode && !ck_reg[7]) [*2] |-> !core_sample && !core_convert)
    else $error("conversion runs in stop");
  a_async_run_gate: assert property (
    async_clock_run |-> ck_reg[7] && (core_sample || core_convert))
    else $error("async clock runs when idle");
  a_upper_zero: assert property (
    s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("upper read bits not zero");
endmodule // adc_ctrl_props
`default_nettype wire

// ===== test/analog_core_model.sv
// Model of the analog converter core: answers each conversion after a
// chosen number of cycles with a chosen code.
// Assumes core_convert is a level from the control block on aclk.
`timescale 1ns/1ps
`default_nettype none
module analog_core_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic core_convert,
  input wire logic [9:0] value,
  input wire logic [4:0] delay,
  output logic [9:0] core_result,
  output logic core_done
);
  logic [4:0] cnt;
  // Outside the done pulse the result lines keep flipping, so a design
  // that captures at the wrong moment sees garbage, not a lucky match.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt <= 5'h00;
      core_done <= 1'b0;
      core_result <= 10'h155;
    end else if (!core_convert) begin
      cnt <= 5'h00;
      core_done <= 1'b0;
      core_result <= ~core_result;
    end else begin
      cnt <= cnt + 5'h01;
      core_done <= (cnt == delay);
      core_result <= (cnt == delay) ? value : ~core_result;
    end
  end
endmodule // analog_core_model
`default_nettype wire

// ===== test/adc_ctrl_test.sv
// Testbench for the converter control top: AXI4-Lite register tasks,
// the core model and directed tests.
// Assumes the package, design, core model and checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
module adc_ctrl_test;
  localparam logic [3:0] SC = adc_ctrl_pkg::OFS_STATUS_CONTROL;
  localparam logic [3:0] HI = adc_ctrl_pkg::OFS_RESULT_HIGH;
  localparam logic [3:0] LO = adc_ctrl_pkg::OFS_RESULT_LOW;
  localparam logic [3:0] CK = adc_ctrl_pkg::OFS_CLOCK_MODE;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hf;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rdat;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, s_axi_awready;
  logic s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic stop_mode = 1'b0, hw_trigger = 1'b0, alt_clk_pin = 1'b0;
  logic async_clk_pin = 1'b0, core_done, core_sample, core_convert;
  logic converter_clock, low_power_config, async_clock_run;
  logic [9:0] core_result, value = 10'h0, last = 10'h0, hold;
  logic [9:0] rv [3] = '{10'h3ff, 10'h006, 10'h1fd};
  logic [4:0] core_channel, delay = 5'h00;
  int failures = 0, checked = 0, cycles = 0, ticks = 0, dones = 0;
  int samples = 0, t0;

  adc_ctrl dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .stop_mode, .hw_trigger, .alt_clk_pin, .async_clk_pin, .core_result,
    .core_done, .core_channel, .core_sample, .core_convert, .converter_clock,
    .low_power_config, .async_clock_run);
  analog_core_model core (.aclk, .aresetn, .core_convert, .value, .delay,
    .core_result, .core_done);

  always #25 aclk = ~aclk;

  ////////////////////////////////////////////////////////////////////////////
  // The async source only toggles while the block asks for it, as the
  // real generator is off between conversions.
  always @(posedge aclk) begin
    cycles <= cycles + 1;
    ticks <= ticks + converter_clock;
    dones <= dones + core_done;
    samples <= samples + (core_sample || core_convert);
    if (cycles % 4 == 3) alt_clk_pin <= ~alt_clk_pin;
    if (async_clock_run && cycles % 2 == 1) async_clk_pin <= ~async_clk_pin;
    if (core_done === 1'b1) begin
      last <= core_result;
      value <= value + 10'h0c5;
    end
    if (cycles == 10000) begin
      failures = failures + 1;
      conclude();
    end
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checked = checked + 1;
    if (got !== exp) begin
      failures = failures + 1;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do @(posedge aclk); while (s_axi_awready !== 1'b1);
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid <= 1'b0;
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    rsp = s_axi_bresp;
  endtask

  task automatic rdc(input logic [3:0] a, input logic [31:0] exp);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    rdat = s_axi_rdata;
    rsp = s_axi_rresp;
    check(rdat, exp);
  endtask

  task automatic wait_done(input int n);
    int goal;
    goal = dones + n;
    while (dones < goal) @(posedge aclk);
  endtask

  task automatic quiet(input int n);
    t0 = samples;
    repeat (n) @(posedge aclk);
    check(samples - t0, 0);
  endtask

  function automatic logic [7:0] rnd(input logic [9:0] r);
    return (r[9:2] == 8'hff) ? 8'hff : r[9:2] + {7'h0, r[1]};
  endfunction

  task automatic fin(input int n);
    $display("test %0d finished, mismatches so far %0d", n, failures);
  endtask

  task automatic conclude();
    $display("comparisons %0d, mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  initial begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rdc(CK, 32'h0);
    rdc(HI, 32'h0);
    rdc(LO, 32'h0);
    rdc(4'h2, 32'h0);
    check({30'h0, rsp}, 32'h2);
    wr(4'h6, 8'h55);
    check({30'h0, rsp}, 32'h2);
    fin(1);
    for (int c = 0; c < 4; c++) begin
      wr(CK, {1'b0, c == 3, 2'(c), 4'h1});
      t0 = ticks;
      repeat (64) @(posedge aclk);
      check(ticks - t0, 64 >> c);
    end
    wr(CK, 8'h00);
    t0 = ticks;
    repeat (64) @(posedge aclk);
    check(ticks - t0, 8);
    fin(2);
    wr(CK, 8'h03);
    value <= 10'h2a5;
    wr(SC, 8'h03);
    wait_done(1);
    rdc(SC, 32'h83);
    rdc(HI, 32'h2);
    rdc(LO, 32'ha5);
    rdc(SC, 32'h03);
    delay <= 5'h14;
    wr(SC, 8'h23);
    wait_done(1);
    hold = last;
    rdc(HI, 32'(hold[9:8]));
    wait_done(2);
    rdc(LO, 32'(hold[7:0]));
    wait_done(1);
    rdc(LO, 32'(last[7:0]));
    fin(3);
    wr(CK, 8'h01);
    quiet(40);
    wr(SC, 8'h23);
    wait_done(1);
    rdc(HI, 32'h0);
    wait_done(1);
    rdc(LO, 32'(rnd(last)));
    stop_mode <= 1'b1;
    repeat (3) @(posedge aclk);
    quiet(30);
    stop_mode <= 1'b0;
    quiet(30);
    fin(4);
    delay <= 5'h00;
    foreach (rv[i]) begin
      value <= rv[i];
      wr(SC, 8'h03);
      wait_done(1);
      rdc(LO, 32'(rnd(rv[i])));
    end
    wr(SC, 8'h1f);
    quiet(40);
    wr(CK, 8'h09);
    wr(SC, 8'h05);
    wait_done(1);
    rdc(SC, 32'h85);
    fin(5);
    wr(CK, 8'h07);
    wr(SC, 8'h02);
    quiet(30);
    hw_trigger <= 1'b1;
    @(posedge aclk);
    hw_trigger <= 1'b0;
    wait_done(1);
    rdc(HI, 32'(last[9:8]));
    rdc(LO, 32'(last[7:0]));
    wr(CK, 8'h83);
    stop_mode <= 1'b1;
    wr(SC, 8'h03);
    wait_done(1);
    rdc(LO, 32'(last[7:0]));
    stop_mode <= 1'b0;
    fin(6);
    conclude();
  end
endmodule // adc_ctrl_test

bind adc_ctrl adc_ctrl_props chk (.aclk, .aresetn, .s_axi_awaddr,
  .s_axi_awvalid, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_bvalid,
  .s_axi_rdata, .s_axi_rvalid, .stop_mode, .core_done, .core_channel,
  .core_sample, .core_convert, .converter_clock, .low_power_config,
  .async_clock_run);
`default_nettype wire
